// [hw/dtc_top.sv]
`timescale 1ns/1ps
module dtc_top #(
	parameter int CYCLE_PERIODS = dtc_pkg::PER_CYCLE_PERIODS
) (
	input  wire logic                    core_clk,
	input  wire logic                    reset_n,
	input  wire logic                    double_speed_mode,
	input  wire dtc_pkg::dtc_chan_ctrl_s chan0_ctrl,
	input  wire dtc_pkg::dtc_chan_ctrl_s chan1_ctrl,
	input  wire logic                    count_pin0,
	input  wire logic                    count_pin1,
	input  wire logic                    ext_irq0_pin,
	input  wire logic                    ext_irq1_pin,
	input  wire dtc_pkg::dtc_byte_wr_s   byte_wr,
	input  wire logic [1:0]              flag_clear,
	input  wire logic [1:0]              irq_service_ack,
	output logic [7:0]                   chan0_low_byte,
	output logic [7:0]                   chan0_high_byte,
	output logic [7:0]                   chan1_low_byte,
	output logic [7:0]                   chan1_high_byte,
	output logic                         chan0_overflow_flag,
	output logic                         chan1_overflow_flag
);
	localparam int DIV_W = $clog2(CYCLE_PERIODS + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLE_PERIODS - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = '0;
	localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);

	initial begin
		if (CYCLE_PERIODS < 2)
			$error("dtc_top: CYCLE_PERIODS must be at least 2");
	end

	// mode 0 keeps the top three bits untouched: they carry no meaning
	function automatic dtc_pkg::dtc_step_s dtc_step(
		input logic [1:0] mode,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		dtc_pkg::dtc_step_s r;
		logic               carry;
		r     = '{low: lo, high: hi, ovf: 1'b0};
		carry = 1'b0;
		case (mode) // see RQ20
			dtc_pkg::MODE_PRESCALE13: begin
				carry  = &lo[dtc_pkg::PRESCALE_BITS-1:0]; // see RQ12
				r.low  = {lo[7:dtc_pkg::PRESCALE_BITS],
					lo[dtc_pkg::PRESCALE_BITS-1:0]
					+ dtc_pkg::PRESCALE_BITS'(1)}; // see RQ13
				r.high = carry ? hi + dtc_pkg::BYTE_ONE : hi;
				r.ovf  = carry & (&hi); // see RQ11
			end
			dtc_pkg::MODE_CASCADE16: begin
				{r.high, r.low} = {hi, lo} + 16'h0001; // see RQ14
				r.ovf           = &{hi, lo}; // see RQ2
			end
			dtc_pkg::MODE_RELOAD8: begin
				r.ovf = &lo; // see RQ15
				r.low = r.ovf ? hi : lo + dtc_pkg::BYTE_ONE;
			end
			default: begin
				r = '{low: lo, high: hi, ovf: 1'b0}; // see RQ23
			end
		endcase
		return r;
	endfunction : dtc_step

	// gate clear: run alone; gate set: irq pin must be high too
	function automatic logic dtc_enabled(
		input dtc_pkg::dtc_chan_ctrl_s c,
		input logic                    irq_level
	);
		return c.run_bit & (~c.gate_bit | irq_level); // see RQ10 RQ21
	endfunction : dtc_enabled

	// peripheral clock and cycle enables
	logic             half_phase;
	logic [DIV_W-1:0] per_div;
	logic             cycle_tick;

	wire per_clk_en = double_speed_mode | half_phase; // see RQ7
	wire div_wrap   = per_clk_en & (per_div == DIV_LAST);
	wire [DIV_W-1:0] next_per_div = div_wrap ? DIV_ZERO
		: (per_clk_en ? per_div + DIV_ONE : per_div);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_phase <= 1'b0;
			per_div    <= DIV_ZERO;
			cycle_tick <= 1'b0;
		end else begin
			half_phase <= ~half_phase;
			per_div    <= next_per_div;
			cycle_tick <= div_wrap; // see RQ6
		end
	end

	// pin sampling
	wire [1:0] count_fall;
	wire [1:0] irq_level;

	dtc_pin_sampler #(.WIDTH(2)) u_count_pins (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.sample_en (cycle_tick),
		.pin_in    ({count_pin1, count_pin0}),
		.pin_level (),
		.pin_fall  (count_fall)
	);

	// irq pins only need their level; sampled every clock
	dtc_pin_sampler #(.WIDTH(2)) u_irq_pins (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.sample_en (1'b1),
		.pin_in    ({ext_irq1_pin, ext_irq0_pin}),
		.pin_level (irq_level),
		.pin_fall  ()
	);

	// event selection
	wire split0 = chan0_ctrl.mode == dtc_pkg::MODE_SPLIT8;
	wire halt1  = chan1_ctrl.mode == dtc_pkg::MODE_SPLIT8;

	wire src0 = (chan0_ctrl.source_select == dtc_pkg::SRC_TIMER)
		? cycle_tick : count_fall[dtc_pkg::CHAN0]; // see RQ1 RQ8
	wire src1 = (chan1_ctrl.source_select == dtc_pkg::SRC_TIMER)
		? cycle_tick : count_fall[dtc_pkg::CHAN1];

	wire en0 = dtc_enabled(chan0_ctrl, irq_level[dtc_pkg::CHAN0]);
	// while channel 0 is split, channel 1 loses its run bit and gate;
	// it then runs freely and only mode 3 stops it
	wire en1 = split0 ? 1'b1
		: dtc_enabled(chan1_ctrl, irq_level[dtc_pkg::CHAN1]); // see RQ23

	wire inc0    = en0 & src0; // see RQ2
	wire inc1    = en1 & src1 & ~halt1; // see RQ22 RQ23
	// high half of a split channel 0 is a pure timer on the chan 1 run bit
	wire inc0_hi = split0 & cycle_tick & chan1_ctrl.run_bit; // see RQ19

	// counting
	wire dtc_pkg::dtc_step_s step0 = dtc_step(chan0_ctrl.mode,
		chan0_low_byte, chan0_high_byte);
	wire dtc_pkg::dtc_step_s step1 = dtc_step(chan1_ctrl.mode,
		chan1_low_byte, chan1_high_byte);

	// split mode: each half of channel 0 is a plain 8-bit counter
	wire [7:0] split_lo  = chan0_low_byte + dtc_pkg::BYTE_ONE; // see RQ18
	wire       split_lo_ovf = &chan0_low_byte;
	wire [7:0] split_hi  = chan0_high_byte + dtc_pkg::BYTE_ONE;
	wire       split_hi_ovf = &chan0_high_byte;

	wire [7:0] cnt0_lo = split0 ? split_lo : step0.low;
	wire [7:0] cnt0_hi = split0 ? split_hi : step0.high;

	// software writes beat counting for the byte they hit
	wire wr0_lo = byte_wr.valid & ~byte_wr.chan & ~byte_wr.high;
	wire wr0_hi = byte_wr.valid & ~byte_wr.chan &  byte_wr.high;
	wire wr1_lo = byte_wr.valid &  byte_wr.chan & ~byte_wr.high;
	wire wr1_hi = byte_wr.valid &  byte_wr.chan &  byte_wr.high;

	// run bit never loads the counters: value held until an event
	wire [7:0] next_chan0_low = wr0_lo ? byte_wr.data
		: (inc0 ? cnt0_lo : chan0_low_byte); // see RQ3
	// a mode 2 reload never writes the high byte
	wire hi0_count = split0 ? inc0_hi : inc0;
	wire [7:0] next_chan0_high = wr0_hi ? byte_wr.data
		: (hi0_count ? cnt0_hi : chan0_high_byte); // see RQ16
	wire [7:0] next_chan1_low = wr1_lo ? byte_wr.data
		: (inc1 ? step1.low : chan1_low_byte);
	wire [7:0] next_chan1_high = wr1_hi ? byte_wr.data
		: (inc1 ? step1.high : chan1_high_byte); // see RQ16

	// overflow flags
	wire set0 = inc0 & (split0 ? split_lo_ovf : step0.ovf); // see RQ11
	// with channel 0 split, channel 1 overflows raise no flag
	wire set1 = (inc0_hi & split_hi_ovf)
		| (inc1 & ~split0 & step1.ovf); // see RQ19

	wire clr0 = flag_clear[dtc_pkg::CHAN0]
		| irq_service_ack[dtc_pkg::CHAN0]; // see RQ17
	wire clr1 = flag_clear[dtc_pkg::CHAN1]
		| irq_service_ack[dtc_pkg::CHAN1];

	// a set in the clearing cycle is kept
	wire next_flag0 = set0 | (chan0_overflow_flag & ~clr0); // see RQ24
	wire next_flag1 = set1 | (chan1_overflow_flag & ~clr1); // see RQ24

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chan0_low_byte  <= dtc_pkg::BYTE_ZERO;
			chan0_high_byte <= dtc_pkg::BYTE_ZERO;
			chan1_low_byte  <= dtc_pkg::BYTE_ZERO;
			chan1_high_byte <= dtc_pkg::BYTE_ZERO;
		end else begin
			chan0_low_byte  <= next_chan0_low;
			chan0_high_byte <= next_chan0_high;
			chan1_low_byte  <= next_chan1_low;
			chan1_high_byte <= next_chan1_high;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chan0_overflow_flag <= 1'b0;
			chan1_overflow_flag <= 1'b0;
		end else begin
			chan0_overflow_flag <= next_flag0;
			chan1_overflow_flag <= next_flag1;
		end
	end

endmodule : dtc_top

// [hw/dtc_pkg.sv]
// Function
// RQ1: two independent 16-bit channels, high and low byte, timer or counter
// RQ2: run bit lets selected input step low byte, carries reach flag
// RQ3: setting run bit keeps the stored count and resumes from it
// RQ4: software clears run bit before presetting counts, else undefined
// RQ5: software clears run bit before changing mode or source select
// RQ6: timer source steps once per peripheral cycle of six periods
// RQ7: peripheral clock is oscillator halved, or undivided in double speed
// RQ8: counter samples pin once per cycle, counts high-then-low samples
// RQ9: external driver holds each count pin level one full cycle
// RQ10: gate clear means run bit alone; gate set adds the irq pin
// RQ11: rollover from all ones to zero sets the overflow flag
// RQ12: mode 0 is five-bit prescaler carrying into the eight-bit high byte
// RQ13: mode 0 upper three low-byte bits are undefined and ignored
// RQ14: mode 1 cascades high and low bytes into one 16-bit counter
// RQ15: mode 2 low byte overflow sets flag and reloads from high byte
// RQ16: mode 2 high byte may be written anytime without disturbing count
// RQ17: interrupt service clears that channel's overflow flag in hardware
// RQ18: mode 3 channel 0 low byte uses channel 0 controls normally
// RQ19: mode 3 channel 0 high byte times cycles on channel 1 bits
// RQ20: two-bit mode field selects modes 0 to 3
// RQ21: with gate set, count only while irq pin high and run set
// RQ22: channel 1 matches channel 0 in modes 0, 1 and 2
// RQ23: channel 1 in mode 3 halts and holds its count
// RQ24: overflow flag stays set until service or software clear
package dtc_pkg;

	localparam logic [1:0] MODE_PRESCALE13 = 2'h0;
	localparam logic [1:0] MODE_CASCADE16  = 2'h1;
	localparam logic [1:0] MODE_RELOAD8    = 2'h2;
	localparam logic [1:0] MODE_SPLIT8     = 2'h3;

	localparam int          PER_CYCLE_PERIODS = 6;
	localparam int          PRESCALE_BITS     = 5;
	localparam logic [7:0]  BYTE_ZERO         = 8'h00;
	localparam logic [7:0]  BYTE_ONE          = 8'h01;
	localparam logic        SRC_TIMER         = 1'b0;
	localparam int          CHAN0             = 0;
	localparam int          CHAN1             = 1;

	typedef struct packed {
		logic       run_bit;
		logic       gate_bit;
		logic       source_select;
		logic [1:0] mode;
	} dtc_chan_ctrl_s;

	typedef struct packed {
		logic       valid;
		logic       chan;
		logic       high;
		logic [7:0] data;
	} dtc_byte_wr_s;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic       ovf;
	} dtc_step_s;

endpackage : dtc_pkg

// [hw/dtc_pin_sampler.sv]
`timescale 1ns/1ps
module dtc_pin_sampler #(
	parameter int WIDTH = 2
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic             sample_en,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_level,
	output logic      [WIDTH-1:0] pin_fall
);
	logic [WIDTH-1:0] sync1;
	logic [WIDTH-1:0] prev_sample;
	wire  [WIDTH-1:0] next_fall = prev_sample & ~pin_level;

	initial begin
		if (WIDTH < 1) $error("dtc_pin_sampler: WIDTH below 1");
	end

	// sync1 feeds pin_level only
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1     <= '0;
			pin_level <= '0;
		end else begin
			sync1     <= pin_in;
			pin_level <= sync1;
		end
	end

	// one sample per peripheral cycle; fall needs two samples
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_sample <= '0;
			pin_fall    <= '0;
		end else if (sample_en) begin
			prev_sample <= pin_level;
			pin_fall    <= next_fall; // see RQ8
		end else begin
			pin_fall    <= '0;
		end
	end
endmodule : dtc_pin_sampler

// [tb/dtc_pin_model.sv]
`timescale 1ns/1ps
module dtc_pin_model #(
	parameter int HOLD = 13
) (
	input  wire logic core_clk,
	input  wire logic active,
	output logic      pin
);
	int n = 0;

	initial pin = 1'h1;

	// only leaves the low level on a wrap, so no low is cut short
	always @(posedge core_clk) begin
		n <= (n == HOLD - 1) ? 0 : n + 1;
		if (n == HOLD - 1)
			pin <= active ? ~pin : 1'h1;
	end
endmodule : dtc_pin_model

// [tb/dtc_top_sva.sv]
`timescale 1ns/1ps
module dtc_top_sva #(
	parameter int CYCLE_PERIODS = 6
) (
	input wire logic                    core_clk,
	input wire logic                    reset_n,
	input wire dtc_pkg::dtc_chan_ctrl_s chan0_ctrl,
	input wire dtc_pkg::dtc_chan_ctrl_s chan1_ctrl,
	input wire dtc_pkg::dtc_byte_wr_s   byte_wr,
	input wire logic [1:0]              flag_clear,
	input wire logic [1:0]              irq_service_ack,
	input wire logic [7:0]              chan0_low_byte,
	input wire logic [7:0]              chan0_high_byte,
	input wire logic [7:0]              chan1_low_byte,
	input wire logic [7:0]              chan1_high_byte,
	input wire logic                    chan0_overflow_flag
);
	wire logic        wr = byte_wr.valid;
	wire logic [15:0] cnt0 = {chan0_high_byte, chan0_low_byte};
	wire logic [1:0]  m0 = chan0_ctrl.mode;
	wire logic        clr0 = flag_clear[0] | irq_service_ack[0];

	// tick_gap_a counts five quiet clocks: needs six periods per cycle
	initial begin
		if (CYCLE_PERIODS < 6)
			$error("dtc_top_sva: tick_gap_a needs six or more periods");
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	stop_hold_a: assert property (
		!chan0_ctrl.run_bit && m0 != 2'h3 && !wr |=> $stable(cnt0))
		else $error("stopped channel 0 moved");
	high_write_a: assert property (
		wr && !byte_wr.chan && byte_wr.high
		|=> chan0_high_byte == $past(byte_wr.data))
		else $error("high byte write lost");
	cascade_step_a: assert property (
		m0 == 2'h1 && !wr
		|=> cnt0 == $past(cnt0) || cnt0 == $past(cnt0) + 16'h1)
		else $error("cascade count jumped");
	wrap_flag_a: assert property (
		(m0 == 2'h1 && !wr && cnt0 == 16'hFFFF) ##1 cnt0 == 16'h0
		|-> chan0_overflow_flag)
		else $error("rollover without flag");
	flag_sticky_a: assert property (
		chan0_overflow_flag && !clr0 |=> chan0_overflow_flag)
		else $error("flag dropped");
	flag_clear_a: assert property (
		clr0 && !chan0_ctrl.run_bit |=> !chan0_overflow_flag)
		else $error("flag not cleared");
	tick_gap_a: assert property (
		$changed(chan0_low_byte) && !$past(wr)
		|=> $stable(chan0_low_byte) [*5])
		else $error("step too soon");
	reload_a: assert property (
		(m0 == 2'h2 && !wr && chan0_low_byte == 8'hFF) ##1
		chan0_low_byte != 8'hFF
		|-> chan0_low_byte == $past(chan0_high_byte) && chan0_overflow_flag)
		else $error("bad reload");
	reload_keep_a: assert property (
		m0 == 2'h2 && !wr |=> $stable(chan0_high_byte))
		else $error("reload moved high byte");
	split_hold_a: assert property (
		chan1_ctrl.mode == 2'h3 && !wr
		|=> $stable({chan1_high_byte, chan1_low_byte}))
		else $error("channel 1 moved in mode 3");
endmodule : dtc_top_sva

bind dtc_top dtc_top_sva #(.CYCLE_PERIODS(CYCLE_PERIODS)) i_dtc_top_sva (
	.core_clk, .reset_n, .chan0_ctrl, .chan1_ctrl, .byte_wr, .flag_clear,
	.irq_service_ack, .chan0_low_byte, .chan0_high_byte, .chan1_low_byte,
	.chan1_high_byte, .chan0_overflow_flag);

// [tb/dtc_top_bench.sv]
`timescale 1ns/1ps
module dtc_top_bench;
	logic       core_clk = 1'h0;
	logic       reset_n = 1'h0;
	logic       double_speed_mode = 1'h1;
	logic       ext_irq0_pin = 1'h0;
	logic       ext_irq1_pin = 1'h0;
	logic       act = 1'h0;
	logic       pin;
	logic [1:0] flag_clear = 2'h0;
	logic [1:0] irq_service_ack = 2'h0;
	logic [7:0] chan0_low_byte;
	logic [7:0] chan0_high_byte;
	logic [7:0] chan1_low_byte;
	logic [7:0] chan1_high_byte;
	logic       chan0_overflow_flag;
	logic       chan1_overflow_flag;
	int         n_errors = 0;
	int         n_tests = 0;
	int         seed = 22;
	int         falls = 0;
	int         cycles = 0;

	dtc_pkg::dtc_chan_ctrl_s chan0_ctrl = '0;
	dtc_pkg::dtc_chan_ctrl_s chan1_ctrl = '0;
	dtc_pkg::dtc_byte_wr_s   byte_wr = '0;

	wire logic [16:0] got0 = {chan0_overflow_flag, chan0_high_byte,
		chan0_low_byte};
	wire logic [16:0] got1 = {chan1_overflow_flag, chan1_high_byte,
		chan1_low_byte};

	dtc_top i_dtc_top (
		.core_clk, .reset_n, .double_speed_mode, .chan0_ctrl, .chan1_ctrl,
		.count_pin0(pin), .count_pin1(pin), .ext_irq0_pin, .ext_irq1_pin,
		.byte_wr, .flag_clear, .irq_service_ack, .chan0_low_byte,
		.chan0_high_byte, .chan1_low_byte, .chan1_high_byte,
		.chan0_overflow_flag, .chan1_overflow_flag);
	dtc_pin_model i_dtc_pin_model (.core_clk, .active(act), .pin);

	always #2 core_clk = ~core_clk;

	always @(negedge pin)
		if (act)
			falls++;

	task automatic stop_test();
		$display("%0d checks, %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	always @(posedge core_clk) begin
		cycles++;
		// a full run needs about a tenth of this
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic wr(logic c, logic h, logic [7:0] d);
		byte_wr = '{1'h1, c, h, d};
		cyc(1);
		byte_wr = '0;
		cyc(1);
	endtask : wr

	task automatic chk(string s, logic [16:0] e, logic [16:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : chk

	function automatic logic [16:0] step(logic [1:0] m, logic [7:0] h,
		logic [7:0] l, int n);
		logic [16:0] r;
		logic        c;
		r = {1'h0, h, l};
		repeat (n) begin
			case (m)
			2'h0: {c, r[15:8], r[4:0]} = {r[15:8], r[4:0]} + 14'h1;
			2'h1: {c, r[15:0]} = r[15:0] + 17'h1;
			default: {c, r[7:0]} = r[7:0] + 9'h1;
			endcase
			if (m == 2'h2 && c)
				r[7:0] = r[15:8];
			r[16] = r[16] | c;
		end
		return r;
	endfunction : step

	function automatic int cnt(dtc_pkg::dtc_chan_ctrl_s c, logic q, int t);
		if (c.gate_bit && !q)
			return 0;
		return c.source_select ? falls : t;
	endfunction : cnt

	initial begin
		logic [31:0] r;
		logic [16:0] e0;
		logic [16:0] e1;
		logic [16:0] eh;
		logic [16:0] mk;
		logic [15:0] p0;
		logic [15:0] p1;
		logic [1:0]  m;
		int          k;
		int          t;
		cyc(8);
		reset_n = 1'h1;
		cyc(2);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			m = 2'(i);
			double_speed_mode = r[0];
			chan0_ctrl = '{1'h0, r[1], r[2], m};
			chan1_ctrl = '{1'h0, r[3], r[4], m};
			ext_irq0_pin = r[5];
			ext_irq1_pin = r[6];
			k = 2 + int'(r[9:7]);
			p0 = {m == 2'h2 ? r[23:16] : 8'hFF, 4'hF, r[13:10]};
			p1 = {m == 2'h2 ? r[31:24] : 8'hFF, 4'hF, r[17:14]};
			wr(1'h0, 1'h1, p0[15:8]);
			wr(1'h0, 1'h0, p0[7:0]);
			wr(1'h1, 1'h1, p1[15:8]);
			wr(1'h1, 1'h0, p1[7:0]);
			flag_clear = 2'h3;
			cyc(1);
			flag_clear = 2'h0;
			falls = 0;
			chan0_ctrl.run_bit = 1'h1;
			chan1_ctrl.run_bit = 1'h1;
			cyc(12);
			act = 1'h1;
			cyc(12 * k);
			act = 1'h0;
			// room for the last fall to pass sync and sampling
			cyc(36);
			chan0_ctrl.run_bit = 1'h0;
			chan1_ctrl.run_bit = 1'h0;
			cyc(8);
			t = (k + 4) * (double_speed_mode ? 2 : 1);
			e0 = step(m, p0[15:8], p0[7:0], cnt(chan0_ctrl, ext_irq0_pin, t));
			e1 = step(m, p1[15:8], p1[7:0], cnt(chan1_ctrl, ext_irq1_pin, t));
			if (m == 2'h3) begin
				eh = step(m, 8'h0, p0[15:8], t);
				e0[15:8] = eh[7:0];
				e1 = {eh[16], p1};
			end
			mk = {9'h1FF, m == 2'h0 ? 8'h1F : 8'hFF};
			chk("chan0 count", e0 & mk, got0 & mk);
			chk("chan1 count", e1 & mk, got1 & mk);
			// one flag cleared by service, the other by software
			irq_service_ack = i[0] ? 2'h1 : 2'h2;
			flag_clear = ~irq_service_ack;
			cyc(1);
			irq_service_ack = 2'h0;
			flag_clear = 2'h0;
			cyc(1);
			chk("flags", 17'h0, {got0[16], got1[16]});
			$display("test %0d mode %0d done", i, m);
		end
		stop_test();
	end
endmodule : dtc_top_bench
